// ---- core/tmrodm_map.sv ----
// Purpose: channel data map of a triple-redundant 4-20 mA output module
// Assumes: slice measurements synchronous to REF_CLK, APB3 zero-wait
// Notes:   readbacks refresh one channel per clock in a rolling scan
//
// Contract
// - eight numbered data groups from one upward
// - one command per output channel, forty
// - -1024 off, 0 is 4 mA, 4096 20 mA
// - state is majority of three slice codes
// - fixed state code encoding, 5 and 0 unused
// - per channel state, voltage, current, fault
// - voltage is median of three slices
// - voltage signed millivolts within +/-32000
// - current is sum of three slices
// - current signed milliamps within +/-32000
// - line fault is majority of slice flags
// - mismatch bits packed in three 16-bit words
// - mismatch set when slice states disagree
`timescale 1ns/1ps
module tmrodm_map #(
    parameter int NCH = tmrodm_pkg::NCH_DEF
) (
    input  wire logic                                 REF_CLK,
    input  wire logic                                 RESET_N,
    input  wire logic                                 PSEL,
    input  wire logic                                 PENABLE,
    input  wire logic                                 PWRITE,
    input  wire logic [11:0]                          PADDR,
    input  wire logic [31:0]                          PWDATA,
    output logic [31:0]                               PRDATA,
    output logic                                      PREADY,
    output logic                                      PSLVERR,
    input  wire tmrodm_pkg::tmrodm_meas_s [NCH-1:0]   SLICE_A,
    input  wire tmrodm_pkg::tmrodm_meas_s [NCH-1:0]   SLICE_B,
    input  wire tmrodm_pkg::tmrodm_meas_s [NCH-1:0]   SLICE_C,
    output tmrodm_pkg::tmrodm_drive_s [NCH-1:0]       DRIVE,
    output logic [3:0]                                PRI_CHASSIS,
    output logic [3:0]                                PRI_SLOT,
    output logic                                      IRQ
);
    import tmrodm_pkg::*;

    // elaboration check on channel count
    if (NCH < 1 || NCH > 40) begin : g_chk
        $error("NCH must lie in 1..40");
    end

    function automatic logic [2:0] vote3(input logic [2:0] a, b, c);
        if (a == b || a == c) vote3 = a;
        else if (b == c) vote3 = b;
        else vote3 = ST_FAULT;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
        if (v > LIM_POS) sat16 = LIM_POS[15:0];
        else if (v < LIM_NEG) sat16 = LIM_NEG[15:0];
        else sat16 = v[15:0];
    endfunction

    function automatic logic signed [15:0] med3(
        input logic signed [15:0] a, b, c);
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        if (c < lo) med3 = lo;
        else if (c > hi) med3 = hi;
        else med3 = c;
    endfunction

    function automatic tmrodm_drive_s drive_of(input logic signed [15:0] c);
        logic [20:0]   p;
        logic [12:0]   k;
        tmrodm_drive_s r;
        k = (c > CMD_FULL) ? CMD_FULL[12:0] : c[12:0];
        p = 21'(k) * UA_NUM;
        r.on = ~c[15];
        r.ua = c[15] ? 16'h0000 : UA_ZERO + p[UA_SH +: 16];
        return r;
    endfunction

    logic signed [15:0] cmd_q [NCH];
    logic [2:0]         st_q  [NCH];
    logic signed [15:0] vo_q  [NCH];
    logic signed [15:0] cu_q  [NCH];
    logic [NCH-1:0]     wf_q;
    logic [NCH-1:0]     mm_q;
    logic [5:0]         idx_q;
    logic [3:0]         chassis_q;
    logic [3:0]         slot_q;
    logic [NEV-1:0]     istat_q;
    logic [NEV-1:0]     imask_q;
    logic [31:0]        prdata_q;
    logic               err_q;
    logic [31:0]        rd_d;
    logic               hit_d;
    logic               wok_d;
    logic [NEV-1:0]     ev_d;
    logic [NEV-1:0]     clr_d;
    logic [47:0]        mm_pad;
    tmrodm_meas_s       sa;
    tmrodm_meas_s       sb;
    tmrodm_meas_s       sc;
    logic [2:0]         nv_st;
    logic signed [15:0] nv_vo;
    logic signed [15:0] nv_cu;
    logic               nv_wf;
    logic               nv_mm;
    logic [3:0]         grp;
    logic [5:0]         ix;
    logic               setup;
    logic               acc;

    assign grp   = PADDR[11:8];
    assign ix    = PADDR[7:2];
    assign setup = PSEL & ~PENABLE;
    assign acc   = PSEL & PENABLE;

    // slices of the channel under scan
    assign sa = SLICE_A[idx_q];
    assign sb = SLICE_B[idx_q];
    assign sc = SLICE_C[idx_q];

    // voted, median and summed values of one channel
    assign nv_st = vote3(sa.state, sb.state, sc.state);
    assign nv_vo = med3(sa.volt, sb.volt, sc.volt);
    assign nv_cu = sat16(18'($signed(sa.curr)) + 18'($signed(sb.curr))
                   + 18'($signed(sc.curr)));
    assign nv_wf = (sa.wflt & sb.wflt) | (sa.wflt & sc.wflt)
                 | (sb.wflt & sc.wflt);
    assign nv_mm = (sa.state != sb.state) | (sa.state != sc.state);

    // events raised by the scan
    assign ev_d[EV_STATE] = nv_st != st_q[idx_q];
    assign ev_d[EV_WFLT]  = nv_wf & ~wf_q[idx_q];
    assign ev_d[EV_MISM]  = nv_mm & ~mm_q[idx_q];

    // rolling channel scan index
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) idx_q <= 6'h00;
        else if (idx_q == 6'(NCH - 1)) idx_q <= 6'h00;
        else idx_q <= idx_q + 6'h01;
    end

    // readback store, one channel per clock
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wf_q <= '0;
            mm_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                st_q[i] <= 3'h0;
                vo_q[i] <= 16'sh0000;
                cu_q[i] <= 16'sh0000;
            end
        end else begin
            st_q[idx_q] <= nv_st;
            vo_q[idx_q] <= sat16(18'(nv_vo));
            cu_q[idx_q] <= nv_cu;
            wf_q[idx_q] <= nv_wf;
            mm_q[idx_q] <= nv_mm;
        end
    end

    // mismatch words, low channel in low bit, top padded with zero
    assign mm_pad = 48'(mm_q);

    // register read decode
    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        wok_d = 1'b0;
        case (grp)
            G_CMD: begin
                if (ix < 6'(NCH)) begin
                    rd_d[15:0] = cmd_q[ix];
                    wok_d = 1'b1;
                end else if (ix == IX_CHASSIS) begin
                    rd_d[3:0] = chassis_q;
                    wok_d = 1'b1;
                end else if (ix == IX_SLOT) begin
                    rd_d[3:0] = slot_q;
                    wok_d = 1'b1;
                end else hit_d = 1'b0;
            end
            G_STATE: begin
                if (ix < 6'(NCH)) rd_d[2:0] = st_q[ix];
                else hit_d = 1'b0;
            end
            G_VOLT: begin
                if (ix < 6'(NCH)) rd_d[15:0] = vo_q[ix];
                else hit_d = 1'b0;
            end
            G_CURR: begin
                if (ix < 6'(NCH)) rd_d[15:0] = cu_q[ix];
                else hit_d = 1'b0;
            end
            G_WFLT: begin
                if (ix < 6'(NCH)) rd_d[0] = wf_q[ix];
                else hit_d = 1'b0;
            end
            G_MISM: begin
                if (ix < 6'(NMWORD)) rd_d[15:0] = mm_pad[ix[1:0]*16 +: 16];
                else hit_d = 1'b0;
            end
            G_SUPV: begin
                if (ix == IX_ISTAT) rd_d[NEV-1:0] = istat_q;
                else if (ix == IX_IMASK) begin
                    rd_d[NEV-1:0] = imask_q;
                    wok_d = 1'b1;
                end else hit_d = 1'b0;
            end
            G_INFO: begin
                if (ix == IX_NGRP) rd_d[3:0] = NGROUP;
                else if (ix == IX_NCH) rd_d[5:0] = 6'(NCH);
                else hit_d = 1'b0;
            end
            default: hit_d = 1'b0;
        endcase
    end

    // read data and error caught in the setup cycle
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else if (setup) begin
            prdata_q <= PWRITE ? 32'h0000_0000 : rd_d;
            err_q    <= PWRITE ? ~wok_d : ~hit_d;
        end
    end

    // channel commands, off at reset
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < NCH; i++) cmd_q[i] <= CMD_OFF;
        end else if (acc && PWRITE && !err_q && grp == G_CMD
                     && ix < 6'(NCH)) begin
            cmd_q[ix] <= PWDATA[15:0];
        end
    end

    // primary position, widths hold chassis 15 and slot 12
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chassis_q <= 4'h0;
            slot_q    <= 4'h0;
        end else if (acc && PWRITE && !err_q && grp == G_CMD) begin
            if (ix == IX_CHASSIS) chassis_q <= PWDATA[3:0];
            if (ix == IX_SLOT) slot_q <= PWDATA[3:0];
        end
    end

    // interrupt mask
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) imask_q <= '0;
        else if (acc && PWRITE && !err_q && grp == G_SUPV
                 && ix == IX_IMASK)
            imask_q <= PWDATA[NEV-1:0];
    end

    // sticky status, read clears only the bits returned; set wins
    assign clr_d = (acc && !PWRITE && grp == G_SUPV && ix == IX_ISTAT)
                 ? prdata_q[NEV-1:0] : '0;

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) istat_q <= '0;
        else istat_q <= (istat_q & ~clr_d) | ev_d;
    end

    // drive setpoints from commands
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < NCH; i++) DRIVE[i] <= '0;
        end else begin
            for (int i = 0; i < NCH; i++)
                DRIVE[i] <= drive_of(cmd_q[i]);
        end
    end

    // bus answers and outputs
    assign PRDATA      = prdata_q;
    assign PREADY      = 1'b1;
    assign PSLVERR     = err_q;
    assign PRI_CHASSIS = chassis_q;
    assign PRI_SLOT    = slot_q;
    assign IRQ         = |(istat_q & imask_q);

    // checks
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_access;
        PSEL && PENABLE;
    endsequence

    AST_APB_READY: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        s_setup ##1 s_access |-> PREADY)
        else $error("access phase not ready");
    AST_VOTE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sa.state == sb.state |=> st_q[$past(idx_q)] == $past(sa.state))
        else $error("voted state differs from agreeing pair");
    AST_MEDIAN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sb.volt == sc.volt |=> vo_q[$past(idx_q)] == sat16(18'($signed($past(sb.volt)))))
        else $error("median voltage wrong");
    AST_VLIM: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sa.volt == sb.volt && sb.volt == sc.volt && $signed(sa.volt) > LIM_POS
        |=> vo_q[$past(idx_q)] == LIM_POS[15:0])
        else $error("voltage not clamped to upper limit");
    AST_SUM: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sb.curr == 16'h0000 && sc.curr == 16'h0000
        |=> cu_q[$past(idx_q)] == sat16(18'($signed($past(sa.curr)))))
        else $error("summed current wrong");
    AST_WFLT: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sa.wflt && sc.wflt |=> wf_q[$past(idx_q)])
        else $error("line fault majority lost");
    AST_MISM: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        sa.state != sc.state |=> mm_q[$past(idx_q)])
        else $error("state disagreement not flagged");
    AST_PAD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        s_setup and (!PWRITE && grp == G_MISM && ix == 6'h02)
        |=> prdata_q[15:NCH-32] == '0)
        else $error("unused mismatch bits set");
    AST_OFF: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        cmd_q[0] == CMD_OFF ##1 cmd_q[0] == CMD_OFF |=> !DRIVE[0].on)
        else $error("off command still drives");
    AST_FULL: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        cmd_q[0] == CMD_FULL |=> DRIVE[0].ua == UA_FULL)
        else $error("full scale not 20 mA");
    AST_SCAN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
        idx_q == 6'(NCH - 1) |=> idx_q == 6'h00)
        else $error("scan did not wrap");
endmodule

// ---- core/tmrodm_pkg.sv ----
// Purpose: shared constants and carriers of the output channel data map
// Assumes: 16-bit channel data, APB byte addresses group<<8 | index<<2
// Notes:   group index lives in paddr[11:8], word index in paddr[7:2]
package tmrodm_pkg;
    localparam int NCH_DEF = 40;
    localparam int NMWORD  = 3;
    localparam int NEV     = 3;
    // group numbers, one address page each
    localparam logic [3:0] G_CMD   = 4'h1;
    localparam logic [3:0] G_STATE = 4'h2;
    localparam logic [3:0] G_VOLT  = 4'h3;
    localparam logic [3:0] G_CURR  = 4'h4;
    localparam logic [3:0] G_WFLT  = 4'h5;
    localparam logic [3:0] G_MISM  = 4'h6;
    localparam logic [3:0] G_SUPV  = 4'h7;
    localparam logic [3:0] G_INFO  = 4'h8;
    localparam logic [3:0] NGROUP  = 4'h8;
    // word indices inside a group
    localparam logic [5:0] IX_CHASSIS = 6'h28;
    localparam logic [5:0] IX_SLOT    = 6'h29;
    localparam logic [5:0] IX_ISTAT   = 6'h00;
    localparam logic [5:0] IX_IMASK   = 6'h01;
    localparam logic [5:0] IX_NGRP    = 6'h00;
    localparam logic [5:0] IX_NCH     = 6'h01;
    // voted state codes
    localparam logic [2:0] ST_FAULT  = 3'h7;
    localparam logic [2:0] ST_NOMEET = 3'h6;
    localparam logic [2:0] ST_ON     = 3'h4;
    localparam logic [2:0] ST_OPEN   = 3'h3;
    localparam logic [2:0] ST_OFF    = 3'h2;
    localparam logic [2:0] ST_NOSUP  = 3'h1;
    // command scaling: 256 counts per mA, 4 mA at zero
    localparam logic signed [15:0] CMD_OFF  = 16'shFC00;
    localparam logic signed [15:0] CMD_FULL = 16'sh1000;
    localparam logic [15:0] UA_ZERO = 16'h0FA0;
    localparam logic [15:0] UA_FULL = 16'h4E20;
    localparam logic [20:0] UA_NUM  = 21'h0007D;
    localparam int          UA_SH   = 5;
    // readback limits, +/-32000
    localparam logic signed [17:0] LIM_POS = 18'sh07D00;
    localparam logic signed [17:0] LIM_NEG = 18'sh38300;
    // interrupt event bits
    localparam int EV_STATE = 0;
    localparam int EV_WFLT  = 1;
    localparam int EV_MISM  = 2;

    typedef struct packed {
        logic [2:0]  state;
        logic [15:0] volt;
        logic [15:0] curr;
        logic        wflt;
    } tmrodm_meas_s;

    typedef struct packed {
        logic        on;
        logic [15:0] ua;
    } tmrodm_drive_s;
endpackage

// ---- test/tmrodm_slices.sv ----
// Purpose: model of the three redundant slices feeding channel readbacks
// Assumes: values change right after a rising clock edge
// Notes:   all channels idle at zero until a test loads them
`timescale 1ns/1ps
module tmrodm_slices
    import tmrodm_pkg::*;
#(
    parameter int NCH = NCH_DEF
) (
    input  wire logic                     clk,
    output tmrodm_meas_s [NCH-1:0]        slice_a,
    output tmrodm_meas_s [NCH-1:0]        slice_b,
    output tmrodm_meas_s [NCH-1:0]        slice_c
);
    // every channel starts quiet on all three slices
    initial begin
        slice_a = '0;
        slice_b = '0;
        slice_c = '0;
    end

    // load one channel (1-based) on all slices at once
    task automatic set_ch(input int ch, input tmrodm_meas_s a,
                          input tmrodm_meas_s b, input tmrodm_meas_s c);
        @(posedge clk);
        slice_a[ch-1] <= a;
        slice_b[ch-1] <= b;
        slice_c[ch-1] <= c;
    endtask
endmodule

// ---- test/tb_tmr_output_channel_data_map.sv ----
// Purpose: self-checking bench of the output channel data map
// Assumes: zero-wait APB slave, rolling scan of NCH cycles
// Notes:   slices model loads readback values per channel
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    error_cnt++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_tmr_output_channel_data_map;
    import tmrodm_pkg::*;
    localparam int N = 40;
    logic                   clk, rst_n, psel, penable, pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic                   pready, pslverr, err, irq;
    logic [3:0]             chas, slot;
    tmrodm_meas_s [N-1:0]   sa, sb, sc;
    tmrodm_drive_s [N-1:0]  drv;
    int                     error_cnt, n_compared;
    int                     cmds[5] = '{-1024, 0, 4096, 256, 1};
    logic [16:0]            drv_ex[5] = '{17'h0, {1'b1, 16'd4000},
        {1'b1, 16'd20000}, {1'b1, 16'd5000}, {1'b1, 16'd4003}};
    logic [2:0]             codes[6] = '{1, 2, 3, 4, 6, 7};

    tmrodm_map #(.NCH(N)) dut (.REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLICE_A(sa),
        .SLICE_B(sb), .SLICE_C(sc), .DRIVE(drv), .PRI_CHASSIS(chas),
        .PRI_SLOT(slot), .IRQ(irq));
    tmrodm_slices #(.NCH(N)) slices (.clk(clk), .slice_a(sa), .slice_b(sb),
        .slice_c(sc));

    // clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [11:0] ad(logic [3:0] g, int ix);
        return {g, 6'(ix), 2'b00};
    endfunction

    // one APB transfer, held until pready is seen at an access edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // access lasts until pready; only the watchdog ends a hang
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before callers look at outputs
        #1;
    endtask

    // wait for a full scan pass to land
    task automatic scan_wait();
        repeat (N + 3) @(posedge clk);
    endtask

    function automatic tmrodm_meas_s m(logic [2:0] s, int v, int c,
                                       logic f);
        return {s, 16'(v), 16'(c), f};
    endfunction

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #200us;
        error_cnt++;
        finish_test();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and map description
        apb(0, ad(G_CMD, 0), 0);
        `CHK("cmd1 reset", 32'h0000FC00, rd)
        `CHK("drive1 reset", 17'h0, drv[0])
        apb(0, ad(G_INFO, IX_NGRP), 0);
        `CHK("group count", 32'h8, rd)
        apb(0, ad(G_INFO, IX_NCH), 0);
        `CHK("chan count", 32'(N), rd)
        apb(0, ad(G_SUPV, IX_ISTAT), 0);
        `CHK("istat reset", 32'h0, rd)
        $display("test reset done");
        // primary position at both ends of the legal ranges
        apb(1, ad(G_CMD, IX_CHASSIS), 32'h1);
        apb(1, ad(G_CMD, IX_SLOT), 32'h8);
        `CHK("chassis main", 4'h1, chas)
        `CHK("slot main", 4'h8, slot)
        apb(1, ad(G_CMD, IX_CHASSIS), 32'hF);
        apb(1, ad(G_CMD, IX_SLOT), 32'hC);
        apb(0, ad(G_CMD, IX_SLOT), 0);
        `CHK("slot read", 32'hC, rd)
        `CHK("chassis exp", 4'hF, chas)
        $display("test position done");
        // command scaling on first and last channel
        for (int i = 0; i < 5; i++) begin
            apb(1, ad(G_CMD, 0), 32'(cmds[i]));
            apb(1, ad(G_CMD, N - 1), 32'(cmds[i]));
            @(posedge clk);
            #1;
            `CHK("drive ch1", drv_ex[i], drv[0])
            `CHK("drive ch40", drv_ex[i], drv[N-1])
        end
        $display("test scaling done");
        // masked events: votes, median, sum, fault on channels 1, 17, 40
        slices.set_ch(1, m(4, 100, 10, 1), m(4, -200, 20, 1),
                      m(3, 300, -5, 0));
        slices.set_ch(17, m(1, 32500, 20000, 1), m(2, 32500, 20000, 0),
                      m(3, 32500, 20000, 0));
        slices.set_ch(N, m(6, 5, -20000, 0), m(6, 7, -20000, 0),
                      m(7, 6, -20000, 0));
        scan_wait();
        `CHK("irq masked", 1'b0, irq)
        apb(0, ad(G_STATE, 0), 0);
        `CHK("state ch1", 32'h4, rd)
        apb(0, ad(G_STATE, 16), 0);
        `CHK("state ch17", 32'h7, rd)
        apb(0, ad(G_STATE, N - 1), 0);
        `CHK("state ch40", 32'h6, rd)
        apb(0, ad(G_VOLT, 0), 0);
        `CHK("volt ch1", 32'd100, rd)
        apb(0, ad(G_VOLT, 16), 0);
        `CHK("volt ch17", 32'h7D00, rd)
        apb(0, ad(G_VOLT, N - 1), 0);
        `CHK("volt ch40", 32'd6, rd)
        apb(0, ad(G_CURR, 0), 0);
        `CHK("curr ch1", 32'd25, rd)
        apb(0, ad(G_CURR, 16), 0);
        `CHK("curr ch17", 32'h7D00, rd)
        apb(0, ad(G_CURR, N - 1), 0);
        `CHK("curr ch40", 32'h8300, rd)
        apb(0, ad(G_WFLT, 0), 0);
        `CHK("fault ch1", 32'h1, rd)
        apb(0, ad(G_WFLT, 16), 0);
        `CHK("fault ch17", 32'h0, rd)
        apb(0, ad(G_MISM, 0), 0);
        `CHK("mism w1", 32'h1, rd)
        apb(0, ad(G_MISM, 1), 0);
        `CHK("mism w2", 32'h1, rd)
        apb(0, ad(G_MISM, 2), 0);
        `CHK("mism w3", 32'h80, rd)
        apb(0, ad(G_SUPV, IX_ISTAT), 0);
        `CHK("istat all", 32'h7, rd)
        apb(0, ad(G_SUPV, IX_ISTAT), 0);
        `CHK("istat cleared", 32'h0, rd)
        $display("test readback done");
        // every state code with agreeing slices on channel 2
        for (int i = 0; i < 6; i++) begin
            slices.set_ch(2, m(codes[i], 0, 0, 0), m(codes[i], 0, 0, 0),
                          m(codes[i], 0, 0, 0));
            scan_wait();
            apb(0, ad(G_STATE, 1), 0);
            `CHK("state code", 32'(codes[i]), rd)
            apb(0, ad(G_MISM, 0), 0);
            `CHK("mism agree", 32'h1, rd)
        end
        $display("test codes done");
        // unmasked state change raises and read clears the interrupt
        apb(0, ad(G_SUPV, IX_ISTAT), 0);
        apb(1, ad(G_SUPV, IX_IMASK), 32'h7);
        slices.set_ch(3, m(4, 0, 0, 0), m(4, 0, 0, 0), m(4, 0, 0, 0));
        scan_wait();
        `CHK("irq raised", 1'b1, irq)
        apb(0, ad(G_SUPV, IX_ISTAT), 0);
        `CHK("istat state", 32'h1, rd)
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test interrupt done");
        // refused accesses leave state untouched
        apb(1, ad(G_STATE, 2), 32'h1);
        `CHK("ro write err", 1'b1, err)
        apb(0, ad(G_STATE, 2), 0);
        `CHK("ro kept", 32'h4, rd)
        apb(0, 12'h900, 0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("test refusal done");
        finish_test();
    end
endmodule
